// ### rtl/bert_pkg.sv
`default_nettype none
package bert_pkg;

    // register byte addresses on the AHB-Lite port (low 8 address bits decoded)
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PATTERN = 8'h04;
    localparam logic [7:0] ADDR_LENGTH  = 8'h08;
    localparam logic [7:0] ADDR_TAP     = 8'h0C;
    localparam logic [7:0] ADDR_ERRINS  = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_RXPAT   = 8'h18;
    localparam logic [7:0] ADDR_ERRCNT  = 8'h1C;
    localparam logic [7:0] ADDR_BITCNT  = 8'h20;

    // pattern_control_reg layout, bit 7 down to bit 0
    typedef struct packed {
        logic       tx_load;
        logic [1:0] spare_hi;
        logic       load_count;
        logic       resync;
        logic       sync_en;
        logic       spare_lo;
        logic       repetitive;
    } bert_ctrl_t;

    // error_insertion_reg layout: rate code 1..7 means one error per 10^code bits
    typedef struct packed {
        logic [3:0] spare;
        logic       single;
        logic [2:0] rate;
    } bert_eir_t;

    // status_reg layout
    typedef struct packed {
        logic [3:0] spare;
        logic       bus_style;
        logic       rx_all_zeros;
        logic       rx_all_ones;
        logic       synced;
    } bert_status_t;

    // indices of the sampled pins
    localparam int PIN_TXC   = 0;
    localparam int PIN_RXC   = 1;
    localparam int PIN_RXD   = 2;
    localparam int PIN_TL    = 3;
    localparam int PIN_LC    = 4;
    localparam int PIN_TEST  = 5;
    localparam int PIN_BTS   = 6;
    localparam int PIN_COUNT = 7;

    localparam bert_ctrl_t  CTRL_RESET    = 8'h00;
    localparam bert_eir_t   EIR_RESET     = 8'h00;
    localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
    localparam logic [4:0]  LENGTH_RESET  = 5'h00;
    localparam logic [4:0]  TAP_RESET     = 5'h00;

    localparam logic [1:0]  TX_LOAD_EDGES = 2'h3;
    localparam logic [1:0]  TX_LOAD_WAIT  = TX_LOAD_EDGES - 2'h1;
    localparam logic [5:0]  SYNC_RUN_LAST = 6'h1F;

    typedef enum logic [1:0] {
        SYNC_HUNT   = 2'b01,
        SYNC_LOCKED = 2'b10
    } bert_sync_t;

    // terminal count of the error spacing counter, 10^code - 1
    function automatic logic [23:0] bert_rate_limit(input logic [2:0] code);
        case (code)
            3'h1:    return 24'h000009;
            3'h2:    return 24'h000063;
            3'h3:    return 24'h0003E7;
            3'h4:    return 24'h00270F;
            3'h5:    return 24'h01869F;
            3'h6:    return 24'h0F423F;
            3'h7:    return 24'h98967F;
            default: return 24'hFFFFFF;
        endcase
    endfunction

endpackage
`default_nettype wire

// ### rtl/bert_top.sv
//
// Contract
// R01: transmit_load rise loads pattern set into generator
// R02: pattern MSB leaves on third tx clock edge
// R03: transmit_load is pin OR control bit 7
// R04: pseudorandom check uses transmit polynomial
// R05: host qualifies lock with all-ones/zeros flags
// R06: repetitive check matches same repetition length
// R07: host qualifies lock using flags and received pattern
// R08: while locked each mismatching bit counts error
// R09: sync enable and resync bits steer synchronizer
// R10: 32-bit error and bit counters
// R11: load_count event delimits integration period
// R12: single or 1e-1..1e-7 error insertion
// R13: host initialises every register after power-up
// R14: primary feedback tap at stage N-1
// R15: second feedback tap programmable to any stage
// R16: repetitive patterns 1 to 32 bits
// R17: pseudorandom registers up to 32 stages
// R18: test input floats every output; here only tx_data and rx_sync_lost float, not the AHB outputs
// R19: load_count rise latches counts, clears counters
// R20: loss-of-sync high until 32 matching bits
// R21: bus style strap selects strobe convention; here the strap is only reported in status, with no effect on the bus
// R22: generator and checker step per line clock edge
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bert_top (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // line and strap pins
    input  wire logic        tx_line_clock,
    input  wire logic        rx_line_clock,
    input  wire logic        rx_data,
    input  wire logic        transmit_load,
    input  wire logic        load_count,
    input  wire logic        test_mode,
    input  wire logic        bus_style_select,
    // line outputs
    output logic             tx_data,
    output logic             tx_data_oe_n,
    output logic             rx_sync_lost,
    output logic             rx_sync_lost_oe_n
);

    logic [bert_pkg::PIN_COUNT-1:0] pin_raw;
    logic [bert_pkg::PIN_COUNT-1:0] pin_meta_q;
    logic [bert_pkg::PIN_COUNT-1:0] pin_sync_q;
    logic [bert_pkg::PIN_COUNT-1:0] pin_prev_q;
    logic [bert_pkg::PIN_COUNT-1:0] pin_rise;

    bert_pkg::bert_ctrl_t   pattern_control_reg;
    bert_pkg::bert_eir_t    error_insertion_reg;
    bert_pkg::bert_status_t status_reg;
    logic [31:0]            pattern_set_regs;
    logic [4:0]             pattern_length_reg;
    logic [4:0]             polynomial_tap_reg;
    logic [31:0]            error_count_reg;
    logic [31:0]            bit_count_reg;

    logic                   wr_pend_q;
    logic [7:0]             wr_addr_q;
    logic [31:0]            hrdata_q;
    logic [31:0]            rd_data;
    logic                   take;

    logic                   bus_style_q;
    logic                   strap_done_q;

    logic                   tl_prev_q;
    logic                   tl_rise;
    logic                   lc_prev_q;
    logic                   lc_rise;

    logic [31:0]            gen_q;
    logic [31:0]            gen_next;
    logic                   gen_fb;
    logic [1:0]             wait_q;
    logic                   tdata_q;
    logic                   tx_emit;
    logic [23:0]            space_q;
    logic                   rate_hit;
    logic                   single_pend_q;
    logic                   inject;

    logic [31:0]            rx_shift_q;
    logic                   rx_edge;
    logic                   rx_bit;
    logic                   expected;
    logic                   match;
    bert_pkg::bert_sync_t   sync_q;
    logic [5:0]             run_q;
    logic                   rx_lost_q;
    logic [31:0]            bit_cnt_q;
    logic [31:0]            err_cnt_q;

    // write strobe decode, used by every writable register
    function automatic logic wr_hit(input logic [7:0] a);
        return wr_pend_q && (wr_addr_q == a);
    endfunction

    // pin synchronisers; the second stage is looked at, the third only to find rising edges
    assign pin_raw = {bus_style_select, test_mode, load_count, transmit_load,
                      rx_data, rx_line_clock, tx_line_clock};
    assign pin_rise = pin_sync_q & ~pin_prev_q;

    // sampling runs through reset: strap valid at release, no false edge after it
    always_ff @(posedge mclk) begin
        if (ce) begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // strap caught once after reset release; reported in status, no bus effect here
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bus_style_q  <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (ce && !strap_done_q) begin
            bus_style_q  <= pin_sync_q[bert_pkg::PIN_BTS]; // [R21]
            strap_done_q <= 1'b1;
        end
    end

    // ahb-lite: zero wait state, hreadyout drops only while frozen
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign take      = hsel && htrans[1] && hready;

    always_comb begin
        case (haddr[7:0])
            bert_pkg::ADDR_CTRL:    rd_data = {24'h000000, pattern_control_reg};
            bert_pkg::ADDR_PATTERN: rd_data = pattern_set_regs;
            bert_pkg::ADDR_LENGTH:  rd_data = {27'h0000000, pattern_length_reg};
            bert_pkg::ADDR_TAP:     rd_data = {27'h0000000, polynomial_tap_reg};
            bert_pkg::ADDR_ERRINS:  rd_data = {24'h000000, error_insertion_reg};
            bert_pkg::ADDR_STATUS:  rd_data = {24'h000000, status_reg};
            bert_pkg::ADDR_RXPAT:   rd_data = rx_shift_q;
            bert_pkg::ADDR_ERRCNT:  rd_data = error_count_reg;
            bert_pkg::ADDR_BITCNT:  rd_data = bit_count_reg;
            default:                rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr[7:0];
            hrdata_q  <= (take && !hwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // software registers, written in the data phase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pattern_control_reg <= bert_pkg::CTRL_RESET;
            pattern_set_regs    <= bert_pkg::PATTERN_RESET;
            pattern_length_reg  <= bert_pkg::LENGTH_RESET;
            polynomial_tap_reg  <= bert_pkg::TAP_RESET;
            error_insertion_reg <= bert_pkg::EIR_RESET;
        end else if (ce) begin
            if (wr_hit(bert_pkg::ADDR_CTRL)) begin
                pattern_control_reg <= hwdata[7:0];
            end
            if (wr_hit(bert_pkg::ADDR_PATTERN)) begin
                pattern_set_regs <= hwdata;
            end
            if (wr_hit(bert_pkg::ADDR_LENGTH)) begin
                pattern_length_reg <= hwdata[4:0]; // [R16] [R17]
            end
            if (wr_hit(bert_pkg::ADDR_TAP)) begin
                polynomial_tap_reg <= hwdata[4:0]; // [R15]
            end
            if (wr_hit(bert_pkg::ADDR_ERRINS)) begin
                error_insertion_reg <= {hwdata[7:4], 1'b0, hwdata[2:0]};
            end
        end
    end

    // load events: pin OR control bit, acted on at the rising edge
    assign tl_rise = (pin_sync_q[bert_pkg::PIN_TL] | pattern_control_reg.tx_load) & ~tl_prev_q; // [R03]
    assign lc_rise = (pin_sync_q[bert_pkg::PIN_LC] | pattern_control_reg.load_count) & ~lc_prev_q; // [R19]

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tl_prev_q <= 1'b0;
            lc_prev_q <= 1'b0;
        end else if (ce) begin
            tl_prev_q <= pin_sync_q[bert_pkg::PIN_TL] | pattern_control_reg.tx_load;
            lc_prev_q <= pin_sync_q[bert_pkg::PIN_LC] | pattern_control_reg.load_count;
        end
    end

    // generator: tap A is stage N-1, tap B programmable; repetitive just recirculates
    assign gen_fb = pattern_control_reg.repetitive ? gen_q[pattern_length_reg] // [R14]
                  : gen_q[pattern_length_reg] ^ gen_q[polynomial_tap_reg];  // [R15]
    assign gen_next = {gen_q[30:0], gen_fb};
    assign tx_emit  = pin_rise[bert_pkg::PIN_TXC] && !tl_rise && (wait_q == 2'h0); // [R22]

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            gen_q   <= bert_pkg::PATTERN_RESET;
            wait_q  <= 2'h0;
            tdata_q <= 1'b0;
        end else if (ce) begin
            if (tl_rise) begin
                gen_q  <= pattern_set_regs; // [R01]
                wait_q <= bert_pkg::TX_LOAD_WAIT; // [R02]
            end else if (pin_rise[bert_pkg::PIN_TXC]) begin
                if (wait_q != 2'h0) begin
                    wait_q <= wait_q - 2'h1; // [R02]
                end else begin
                    gen_q   <= gen_next; // [R22]
                    tdata_q <= gen_q[pattern_length_reg] ^ inject; // [R02] [R12]
                end
            end
        end
    end

    // error insertion: spacing counter of sent bits, plus a one-shot request
    assign rate_hit = (error_insertion_reg.rate != 3'h0)
                   && (space_q == bert_pkg::bert_rate_limit(error_insertion_reg.rate));
    assign inject   = rate_hit || single_pend_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            space_q <= 24'h000000;
        end else if (ce) begin
            if (wr_hit(bert_pkg::ADDR_ERRINS)) begin
                space_q <= 24'h000000;
            end else if (tx_emit) begin
                space_q <= rate_hit ? 24'h000000 : space_q + 24'h000001; // [R12]
            end
        end
    end

    // a new request in the cycle the old one is used keeps the flag set
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            single_pend_q <= 1'b0;
        end else if (ce) begin
            if (wr_hit(bert_pkg::ADDR_ERRINS) && hwdata[3]) begin
                single_pend_q <= 1'b1; // [R12]
            end else if (tx_emit) begin
                single_pend_q <= 1'b0;
            end
        end
    end

    // receive checker: expected bit predicted from the last N received bits
    assign rx_edge  = pin_rise[bert_pkg::PIN_RXC];
    assign rx_bit   = pin_sync_q[bert_pkg::PIN_RXD];
    assign expected = pattern_control_reg.repetitive ? rx_shift_q[pattern_length_reg] // [R06]
                    : rx_shift_q[pattern_length_reg] ^ rx_shift_q[polynomial_tap_reg]; // [R04]
    // plain xor feedback would reject a stuck-high line; accept it so only the flags tell
    assign match    = (rx_bit == expected)
                   || (!pattern_control_reg.repetitive && rx_bit && status_reg.rx_all_ones);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rx_shift_q <= 32'h0000_0000;
        end else if (ce && rx_edge) begin
            rx_shift_q <= {rx_shift_q[30:0], rx_bit}; // [R22]
        end
    end

    // synchronizer; a stuck line also fits, so software checks the flags
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sync_q <= bert_pkg::SYNC_HUNT;
            run_q  <= 6'h00;
        end else if (ce) begin
            if (pattern_control_reg.resync) begin
                sync_q <= bert_pkg::SYNC_HUNT; // [R09]
                run_q  <= 6'h00;
            end else begin
                case (sync_q)
                    bert_pkg::SYNC_HUNT: begin
                        if (rx_edge) begin
                            if (!match) begin
                                run_q <= 6'h00;
                            end else if (run_q == bert_pkg::SYNC_RUN_LAST) begin
                                if (pattern_control_reg.sync_en) begin
                                    sync_q <= bert_pkg::SYNC_LOCKED; // [R09] [R20]
                                end
                            end else begin
                                run_q <= run_q + 6'h01; // [R20]
                            end
                        end
                    end
                    bert_pkg::SYNC_LOCKED: begin
                        run_q <= 6'h00;
                    end
                    default: begin
                        sync_q <= bert_pkg::SYNC_HUNT;
                        run_q  <= 6'h00;
                    end
                endcase
            end
        end
    end

    // running counters; the load event restarts them with the current bit
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bit_cnt_q       <= 32'h0000_0000;
            err_cnt_q       <= 32'h0000_0000;
            bit_count_reg   <= 32'h0000_0000;
            error_count_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (lc_rise) begin
                bit_count_reg   <= bit_cnt_q; // [R19] [R11]
                error_count_reg <= err_cnt_q; // [R19]
                bit_cnt_q <= {31'h00000000, rx_edge && (sync_q == bert_pkg::SYNC_LOCKED)};
                err_cnt_q <= {31'h00000000, rx_edge && (sync_q == bert_pkg::SYNC_LOCKED)
                                            && !match};
            end else if (rx_edge && (sync_q == bert_pkg::SYNC_LOCKED)) begin
                bit_cnt_q <= bit_cnt_q + 32'h0000_0001; // [R10]
                if (!match) begin
                    err_cnt_q <= err_cnt_q + 32'h0000_0001; // [R08] [R10]
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rx_lost_q <= 1'b1;
        end else if (ce) begin
            rx_lost_q <= (sync_q != bert_pkg::SYNC_LOCKED); // [R20]
        end
    end

    always_comb begin
        status_reg              = '0;
        status_reg.synced       = (sync_q == bert_pkg::SYNC_LOCKED);
        status_reg.rx_all_ones  = (rx_shift_q == 32'hFFFF_FFFF);
        status_reg.rx_all_zeros = (rx_shift_q == 32'h0000_0000);
        status_reg.bus_style    = bus_style_q;
    end

    // enables come straight from the synchronised test pin flop
    assign tx_data           = tdata_q;
    assign rx_sync_lost      = rx_lost_q;
    assign tx_data_oe_n      = pin_sync_q[bert_pkg::PIN_TEST]; // [R18]
    assign rx_sync_lost_oe_n = pin_sync_q[bert_pkg::PIN_TEST]; // [R18]

endmodule // bert_top
`default_nettype wire

// ### tb/bert_chan_model.sv
`timescale 1ns/1ns
`default_nettype none
module bert_chan_model (
    // line side of the tester
    input  wire logic       tx_data,
    output logic            line_clk,
    output logic            rx_data,
    // fault commands: 0 clean loop, 2 stuck high; flip inverts every bit retimed while it is high
    input  wire logic [1:0] fault,
    input  wire logic       flip
);
    // line clock runs free, well under a quarter of the system clock
    initial begin
        line_clk = 1'b0;
        rx_data  = 1'b0;
        forever #300 line_clk = ~line_clk;
    end

    // retimed mid-bit so the receiver never samples a moving bit
    always @(negedge line_clk) begin
        rx_data <= (fault == 2'h2) ? 1'b1 : (tx_data ^ flip);
    end
endmodule // bert_chan_model
`default_nettype wire

// ### tb/bert_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module bert_top_chk (
    // clock, reset, enable
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        ce,
    // register bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // line side
    input wire logic        tx_line_clock,
    input wire logic        rx_line_clock,
    input wire logic        test_mode,
    input wire logic        tx_data,
    input wire logic        tx_data_oe_n,
    input wire logic        rx_sync_lost,
    input wire logic        rx_sync_lost_oe_n
);
    logic [2:0] txs_q;
    logic [2:0] rxs_q;
    logic [2:0] age_q;
    logic [5:0] run_q;
    logic       rd_q;

    // own synchronisers mirror the pin delay, so edge ages line up with the design
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            txs_q <= 3'h0;
            rxs_q <= 3'h0;
            age_q <= 3'h7;
            run_q <= 6'h00;
            rd_q  <= 1'b0;
        end else if (ce) begin
            txs_q <= {txs_q[1:0], tx_line_clock};
            rxs_q <= {rxs_q[1:0], rx_line_clock};
            age_q <= (txs_q[1] & ~txs_q[2]) ? 3'h0 : (age_q == 3'h7 ? 3'h7 : age_q + 3'h1);
            if (!rx_sync_lost)
                run_q <= 6'h00;
            else if (rxs_q[1] & ~rxs_q[2] & (run_q != 6'h3F))
                run_q <= run_q + 6'h01;
            rd_q  <= hsel & htrans[1] & hready & ~hwrite;
        end
    end

    AST_TX_ON_EDGE: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(tx_data) |-> age_q <= 3'h2) else $error("tx bit moved off a line clock edge");
    AST_LOCK_RUN: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(rx_sync_lost) |-> run_q >= 6'h20) else $error("lock before 32 received bits");
    AST_TEST_FLOAT: assert property (@(posedge mclk) disable iff (!rstn)
        test_mode [*5] |-> tx_data_oe_n && rx_sync_lost_oe_n) else $error("outputs driven in test");
    AST_TEST_DRIVE: assert property (@(posedge mclk) disable iff (!rstn)
        !test_mode [*5] |-> !tx_data_oe_n && !rx_sync_lost_oe_n) else $error("outputs floating");
    AST_HRESP_OKAY: assert property (@(posedge mclk) disable iff (!rstn)
        hresp == 1'b0) else $error("bus error response");
    AST_READY_CE: assert property (@(posedge mclk) disable iff (!rstn)
        hreadyout == ce) else $error("ready does not follow enable");
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rstn)
        !rd_q |-> hrdata == 32'h0000_0000) else $error("read data outside data phase");
    AST_RESET_LINE: assert property (@(posedge mclk)
        !rstn && ce |=> rx_sync_lost && !tx_data) else $error("line outputs not at reset level");
endmodule // bert_top_chk

bind bert_top bert_top_chk u_chk (.mclk, .rstn, .ce, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .tx_line_clock, .rx_line_clock, .test_mode, .tx_data, .tx_data_oe_n,
    .rx_sync_lost, .rx_sync_lost_oe_n);
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        mclk, rstn, ce, hsel, hwrite, tl, lcnt, tmode, flip;
    logic [1:0]  htrans, fault;
    logic [31:0] haddr, hwdata, hrdata;
    logic        hreadyout, hresp, tx_data, tx_oe_n, lost, lost_oe_n, lclk, rxd;
    int          n_mismatch, n_checks, cyc;

    bert_top uut (.mclk(mclk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_line_clock(lclk),
        .rx_line_clock(lclk), .rx_data(rxd), .transmit_load(tl), .load_count(lcnt),
        .test_mode(tmode), .bus_style_select(1'b1), .tx_data(tx_data), .tx_data_oe_n(tx_oe_n),
        .rx_sync_lost(lost), .rx_sync_lost_oe_n(lost_oe_n));
    bert_chan_model u_chan (.tx_data(tx_data), .line_clk(lclk), .rx_data(rxd), .fault(fault),
        .flip(flip));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    // one single ahb-lite transfer; read data taken at the closing edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] lo, hi, mask);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q & mask, lo, hi);
    endtask

    task automatic bits(input int n);
        repeat (n) @(negedge lclk);
    endtask

    task automatic latch();
        @(posedge mclk);
        lcnt <= 1'b1;
        bits(2);
        @(posedge mclk);
        lcnt <= 1'b0;
    endtask

    // load a pattern, follow it bit by bit from the third edge, then expect lock
    task automatic tx_run(input logic [31:0] seed, input int n, tap, input logic rep, pin, ones);
        logic [31:0] s;
        s = seed;
        wr(bert_pkg::ADDR_PATTERN, seed);
        wr(bert_pkg::ADDR_LENGTH, 32'(n - 1));
        wr(bert_pkg::ADDR_TAP, 32'(tap));
        wr(bert_pkg::ADDR_CTRL, 32'h0000_000C | 32'(rep));
        @(negedge lclk);
        if (pin) begin
            @(posedge mclk);
            tl <= 1'b1;
            wr(bert_pkg::ADDR_CTRL, 32'h0000_0004 | 32'(rep));
        end else
            wr(bert_pkg::ADDR_CTRL, 32'h0000_0084 | 32'(rep));
        rdc(bert_pkg::ADDR_STATUS, 32'h0, 32'h0, 32'h1);
        chk({31'h0, lost}, 32'h1, 32'h1);
        bits(2);
        for (int k = 0; k < 80; k++) begin
            @(negedge lclk);
            chk({31'h0, tx_data}, {31'h0, s[n-1]}, {31'h0, s[n-1]});
            s = {s[30:0], rep ? s[n-1] : s[n-1] ^ s[tap]};
        end
        @(posedge mclk);
        tl <= 1'b0;
        rdc(bert_pkg::ADDR_STATUS, 32'h9 | {ones, 1'b0}, 32'h9 | {ones, 1'b0}, 32'hF);
        chk({31'h0, lost}, 32'h0, 32'h0);
        if (ones)
            rdc(bert_pkg::ADDR_RXPAT, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    endtask

    initial begin
        {rstn, hsel, hwrite, tl, lcnt, tmode, flip} = '0;
        {htrans, fault, haddr, hwdata} = '0;
        ce = 1'b1;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        rdc(bert_pkg::ADDR_STATUS, 32'h8, 32'h8, 32'h9);
        wr(bert_pkg::ADDR_ERRINS, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rdc(8'h40, 32'h0, 32'h0, 32'hFFFF_FFFF);
        tx_run(32'hA5C3_0F71, 32, 0, 1'b1, 1'b0, 1'b0);
        tx_run(32'h0000_0001, 1, 0, 1'b1, 1'b1, 1'b1);
        tx_run(32'h0000_007F, 7, 5, 1'b0, 1'b0, 1'b0);
        tx_run(32'h1234_5678, 32, 21, 1'b0, 1'b1, 1'b0);
        latch();
        bits(20);
        wr(bert_pkg::ADDR_CTRL, 32'h0000_0014);
        wr(bert_pkg::ADDR_CTRL, 32'h0000_0004);
        rdc(bert_pkg::ADDR_ERRCNT, 32'd0, 32'd0, 32'hFFFF_FFFF);
        rdc(bert_pkg::ADDR_BITCNT, 32'd21, 32'd24, 32'hFFFF_FFFF);
        @(negedge lclk);
        repeat (2) @(posedge mclk);
        flip <= 1'b1;
        @(negedge lclk);
        repeat (2) @(posedge mclk);
        flip <= 1'b0;
        bits(80);
        latch();
        rdc(bert_pkg::ADDR_ERRCNT, 32'd1, 32'd3, 32'hFFFF_FFFF);
        wr(bert_pkg::ADDR_ERRINS, 32'h0000_0008);
        bits(80);
        latch();
        rdc(bert_pkg::ADDR_ERRCNT, 32'd1, 32'd3, 32'hFFFF_FFFF);
        wr(bert_pkg::ADDR_ERRINS, 32'h0000_0001);
        bits(100);
        latch();
        wr(bert_pkg::ADDR_ERRINS, 32'h0000_0000);
        rdc(bert_pkg::ADDR_ERRCNT, 32'd9, 32'd33, 32'hFFFF_FFFF);
        // stuck line passes the polynomial test, flags must show it
        fault <= 2'h2;
        wr(bert_pkg::ADDR_CTRL, 32'h0000_000C);
        wr(bert_pkg::ADDR_CTRL, 32'h0000_0004);
        bits(80);
        rdc(bert_pkg::ADDR_STATUS, 32'hB, 32'hB, 32'hF);
        fault <= 2'h0;
        wr(bert_pkg::ADDR_CTRL, 32'h0000_0008);
        wr(bert_pkg::ADDR_CTRL, 32'h0000_0000);
        bits(80);
        rdc(bert_pkg::ADDR_STATUS, 32'h8, 32'h8, 32'h9);
        @(posedge mclk);
        ce <= 1'b0;
        @(posedge mclk);
        chk({31'h0, hreadyout}, 32'h0, 32'h0);
        ce <= 1'b1;
        tmode <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({31'h0, tx_oe_n & lost_oe_n}, 32'h1, 32'h1);
        tmode <= 1'b0;
        repeat (6) @(posedge mclk);
        chk({31'h0, tx_oe_n | lost_oe_n}, 32'h0, 32'h0);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
